// *** sdram_pkg.sv ***
// constants, command codes and carrier types of the sdram command interface
// assumes a single clock domain shared with the external memory controller
`default_nettype none

package sdram_pkg;

  // array geometry
  localparam int BANKS   = 4;
  localparam int ROWS    = 4096;
  localparam int COLS    = 256;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int BANK_W  = 2;
  localparam int ROW_W   = 12;
  localparam int COL_W   = 8;
  localparam int INDEX_W = BANK_W + ROW_W + COL_W;
  localparam int WORDS   = BANKS * ROWS * COLS;

  // {row_strobe_n, col_strobe_n, write_strobe_n} codes
  localparam logic [2:0] CODE_NOP   = 3'h7;
  localparam logic [2:0] CODE_ACT   = 3'h3;
  localparam logic [2:0] CODE_READ  = 3'h5;
  localparam logic [2:0] CODE_WRITE = 3'h4;
  localparam logic [2:0] CODE_TERM  = 3'h6;
  localparam logic [2:0] CODE_PRE   = 3'h2;
  localparam logic [2:0] CODE_REF   = 3'h1;
  localparam logic [2:0] CODE_MODE  = 3'h0;

  // address bit that selects auto precharge or precharge-all
  localparam int PRECHARGE_SELECT_BIT = 10;

  // mode word fields
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam logic [2:0] BL_CODE_1    = 3'h0;
  localparam logic [2:0] BL_CODE_2    = 3'h1;
  localparam logic [2:0] BL_CODE_4    = 3'h2;
  localparam logic [2:0] BL_CODE_8    = 3'h3;
  localparam logic [2:0] BL_CODE_PAGE = 3'h7;

  // reset values
  localparam logic [11:0] MODE_RESET    = 12'h020;
  localparam logic [11:0] REFRESH_RESET = 12'h000;

  // read pipeline depth and byte mask delay on reads
  localparam int READ_PIPE  = 3;
  localparam int MASK_DELAY = 2;

  typedef struct packed {
    logic              clock_gate_enable;
    logic              chip_select_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              write_strobe_n;
    logic [BANK_W-1:0] bank_select;
    logic [ROW_W-1:0]  addr;
    logic [LANES-1:0]  byte_mask;
  } cmd_pins_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_SELF = 2'b10
  } power_t;

  typedef struct packed {
    power_t                                power;
    logic [ROW_W-1:0]                      mode;
    logic [BANKS-1:0]                      open;
    logic [BANKS-1:0][ROW_W-1:0]           row;
    logic [ROW_W-1:0]                      refresh_row;
    logic                                  burst_active;
    logic                                  burst_write;
    logic                                  burst_ap;
    logic                                  burst_full;
    logic [BANK_W-1:0]                     burst_bank;
    logic [COL_W-1:0]                      burst_col;
    logic [COL_W-1:0]                      burst_left;
    logic [COL_W-1:0]                      burst_wrap;
    logic [READ_PIPE-1:0][DATA_W-1:0]      rd_data;
    logic [READ_PIPE-1:0]                  rd_valid;
    logic [MASK_DELAY-1:0][LANES-1:0]      mask_pipe;
  } state_t;

endpackage

`default_nettype wire

// *** sdram_command_interface.sv ***
// command decoder, bank tracking, burst engine and storage array of the sdram
// assumes the controller runs on core_clk and keeps its own timing waits
//
// Behaviour
// - sample all inputs except reset on rising clock edge
// - four banks, 4096 rows, 256 columns, 32 bits
// - activate latches bank and row address
// - read/write take start column from addr[7:0]
// - decode strobes into eight commands
// - chip select high executes nothing new
// - nop leaves running operations untouched
// - refresh code: clock enable high auto, low self
// - mode load takes op-code from address
// - activated row stays open until precharge
// - precharge select bit enables auto precharge
// - auto precharge closes row at burst end
// - mask delay zero on writes, two reads
// - masked read lane floats two clocks later
// - masked write lanes stay unwritten
// - precharge one bank or all banks
// - precharged bank needs activate before access
// - burst terminate truncates latest burst
// - auto refresh uses internal row counter
`timescale 1ns/10ps
`default_nettype none

module sdram_command_interface (
  input  wire logic                             core_clk,
  input  wire logic                             reset,
  input  wire sdram_pkg::cmd_pins_t             pins,
  input  wire logic [sdram_pkg::DATA_W-1:0]     data_in,
  output logic      [sdram_pkg::DATA_W-1:0]     data_out,
  output logic      [sdram_pkg::LANES-1:0]      data_oe,
  output logic                                  self_refresh_active,
  output logic      [sdram_pkg::ROW_W-1:0]      refresh_row
);

  sdram_pkg::state_t                 st_reg;
  sdram_pkg::state_t                 st_next;
  logic [2:0]                        cmd;
  logic                              live;
  logic                              is_act;
  logic                              is_rd;
  logic                              is_wr;
  logic                              is_term;
  logic                              is_pre;
  logic                              is_ref;
  logic                              is_mode;
  logic                              self_entry;
  logic                              new_rw;
  logic                              pre_hits_burst;
  logic                              acc_valid;
  logic                              acc_write;
  logic [sdram_pkg::BANK_W-1:0]      acc_bank;
  logic [sdram_pkg::COL_W-1:0]       acc_col;
  logic [sdram_pkg::INDEX_W-1:0]     mem_index;
  logic [sdram_pkg::DATA_W-1:0]      rd_word;
  logic [sdram_pkg::COL_W-1:0]       wrap_mask;
  logic                              wrap_full;
  logic                              burst_done;
  logic [1:0]                        cl_idx;
  logic                              cmd_none;

  // command decode; deselect executes nothing, stopped clock only self refresh entry
  assign cmd  = {pins.row_strobe_n, pins.col_strobe_n, pins.write_strobe_n};
  assign live = (st_reg.power == sdram_pkg::ST_RUN) && !pins.chip_select_n
                && pins.clock_gate_enable;
  assign is_act     = live && (cmd == sdram_pkg::CODE_ACT);
  assign is_rd      = live && (cmd == sdram_pkg::CODE_READ);
  assign is_wr      = live && (cmd == sdram_pkg::CODE_WRITE);
  assign is_term    = live && (cmd == sdram_pkg::CODE_TERM);
  assign is_pre     = live && (cmd == sdram_pkg::CODE_PRE);
  assign is_ref     = live && (cmd == sdram_pkg::CODE_REF);
  assign is_mode    = live && (cmd == sdram_pkg::CODE_MODE);
  assign self_entry = (st_reg.power == sdram_pkg::ST_RUN) && !pins.chip_select_n
                      && !pins.clock_gate_enable
                      && (cmd == sdram_pkg::CODE_REF);
  assign cmd_none   = !(is_act || is_rd || is_wr || is_term || is_pre
                        || is_ref || is_mode || self_entry);

  // burst length from the mode word
  always_comb
  begin
    wrap_full = 1'b0;
    unique case (st_reg.mode[sdram_pkg::BL_LSB +: 3])
      sdram_pkg::BL_CODE_1:    wrap_mask = 8'h00;
      sdram_pkg::BL_CODE_2:    wrap_mask = 8'h01;
      sdram_pkg::BL_CODE_4:    wrap_mask = 8'h03;
      sdram_pkg::BL_CODE_8:    wrap_mask = 8'h07;
      sdram_pkg::BL_CODE_PAGE:
      begin
        wrap_mask = 8'hff;
        wrap_full = 1'b1;
      end
      default:                 wrap_mask = 8'h00;
    endcase
  end

  // access of this edge: a new command or the running burst
  assign new_rw = (is_rd || is_wr) && st_reg.open[pins.bank_select];
  assign pre_hits_burst = is_pre && st_reg.burst_active
                          && (pins.addr[sdram_pkg::PRECHARGE_SELECT_BIT]
                              || (pins.bank_select == st_reg.burst_bank));
  assign acc_valid = new_rw
                     || (st_reg.burst_active && !is_term && !pre_hits_burst);
  assign acc_write = new_rw ? is_wr : st_reg.burst_write;
  assign acc_bank  = new_rw ? pins.bank_select : st_reg.burst_bank;
  assign acc_col   = new_rw ? pins.addr[sdram_pkg::COL_W-1:0]
                            : st_reg.burst_col;
  assign mem_index = {acc_bank, st_reg.row[acc_bank], acc_col};
  assign burst_done = st_reg.burst_active && !st_reg.burst_full
                      && (st_reg.burst_left == 8'h01) && !new_rw
                      && !is_term && !pre_hits_burst;

  // storage, one array per byte lane, written with zero-delay mask
  for (genvar g = 0; g < sdram_pkg::LANES; g++)
  begin : lane
    logic [7:0] cells [0:sdram_pkg::WORDS-1];
    always_ff @(posedge core_clk)
    begin
      if (acc_valid && acc_write && !pins.byte_mask[g])
      begin
        cells[mem_index] <= data_in[8*g +: 8];
      end
    end
    assign rd_word[8*g +: 8] = cells[mem_index];
  end

  always_comb
  begin
    st_next = st_reg;
    // read pipeline and read mask pipeline
    st_next.rd_data  = {st_reg.rd_data[sdram_pkg::READ_PIPE-2:0], rd_word};
    st_next.rd_valid = {st_reg.rd_valid[sdram_pkg::READ_PIPE-2:0],
                        acc_valid && !acc_write};
    st_next.mask_pipe = {st_reg.mask_pipe[sdram_pkg::MASK_DELAY-2:0],
                         pins.byte_mask};
    // burst engine
    if (new_rw)
    begin
      if (st_reg.burst_active && st_reg.burst_ap
          && (st_reg.burst_bank != pins.bank_select))
      begin
        st_next.open[st_reg.burst_bank] = 1'b0;
      end
      st_next.burst_active = (wrap_mask != 8'h00);
      st_next.burst_write  = is_wr;
      st_next.burst_ap     = pins.addr[sdram_pkg::PRECHARGE_SELECT_BIT];
      st_next.burst_full   = wrap_full;
      st_next.burst_bank   = pins.bank_select;
      st_next.burst_wrap   = wrap_mask;
      st_next.burst_left   = wrap_mask;
      st_next.burst_col    = (pins.addr[7:0] & ~wrap_mask)
                             | ((pins.addr[7:0] + 8'h01) & wrap_mask);
      if ((wrap_mask == 8'h00) && pins.addr[sdram_pkg::PRECHARGE_SELECT_BIT])
      begin
        st_next.open[pins.bank_select] = 1'b0;
      end
    end
    else if (st_reg.burst_active)
    begin
      st_next.burst_col  = (st_reg.burst_col & ~st_reg.burst_wrap)
                           | ((st_reg.burst_col + 8'h01) & st_reg.burst_wrap);
      st_next.burst_left = st_reg.burst_left - 8'h01;
      if (is_term || pre_hits_burst)
      begin
        st_next.burst_active = 1'b0;
      end
      else if (burst_done)
      begin
        st_next.burst_active = 1'b0;
        if (st_reg.burst_ap)
        begin
          st_next.open[st_reg.burst_bank] = 1'b0;
        end
      end
    end
    // bank commands
    if (is_act)
    begin
      st_next.open[pins.bank_select] = 1'b1;
      st_next.row[pins.bank_select]  = pins.addr;
    end
    if (is_pre)
    begin
      if (pins.addr[sdram_pkg::PRECHARGE_SELECT_BIT])
      begin
        st_next.open = '0;
      end
      else
      begin
        st_next.open[pins.bank_select] = 1'b0;
      end
    end
    if (is_mode)
    begin
      st_next.mode = pins.addr;
    end
    // refresh and power state
    unique case (st_reg.power)
      sdram_pkg::ST_RUN:
      begin
        if (is_ref || self_entry)
        begin
          st_next.refresh_row = st_reg.refresh_row + 12'h001;
        end
        if (self_entry)
        begin
          st_next.power = sdram_pkg::ST_SELF;
        end
      end
      sdram_pkg::ST_SELF:
      begin
        if (pins.clock_gate_enable)
        begin
          st_next.power = sdram_pkg::ST_RUN;
        end
      end
      default:
      begin
        st_next.power = sdram_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg             <= '0;
      st_reg.power       <= sdram_pkg::ST_RUN;
      st_reg.mode        <= sdram_pkg::MODE_RESET;
      st_reg.refresh_row <= sdram_pkg::REFRESH_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // output stage, tap chosen by read latency field
  assign cl_idx   = (st_reg.mode[sdram_pkg::CL_LSB +: 2] == 2'h0) ? 2'h0
                    : st_reg.mode[sdram_pkg::CL_LSB +: 2] - 2'h1;
  assign data_out = st_reg.rd_data[cl_idx];
  assign data_oe  = {sdram_pkg::LANES{st_reg.rd_valid[cl_idx]}}
                    & ~st_reg.mask_pipe[sdram_pkg::MASK_DELAY-1];
  assign self_refresh_active = (st_reg.power == sdram_pkg::ST_SELF);
  assign refresh_row         = st_reg.refresh_row;

  // checks
  act_latch_a: assert property (@(posedge core_clk) disable iff (reset)
    is_act |=> st_reg.open[$past(pins.bank_select)]
               && (st_reg.row[$past(pins.bank_select)] == $past(pins.addr)))
    else $error("activate did not latch bank and row");

  pre_one_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_pre && !pins.addr[10]) |=> !st_reg.open[$past(pins.bank_select)])
    else $error("single bank precharge left bank open");

  pre_all_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_pre && pins.addr[10]) |=> (st_reg.open == 4'h0))
    else $error("precharge all left a bank open");

  mode_load_a: assert property (@(posedge core_clk) disable iff (reset)
    is_mode |=> (st_reg.mode == $past(pins.addr)))
    else $error("mode word not taken from address");

  deselect_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (pins.chip_select_n && !st_reg.burst_active) |=> $stable(st_reg.open)
    && $stable(st_reg.mode) && $stable(st_reg.refresh_row))
    else $error("deselect changed device state");

  nop_keeps_burst_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_none && st_reg.burst_active && st_reg.burst_full) |=> st_reg.burst_active)
    else $error("nop disturbed a running burst");

  read_mask_a: assert property (@(posedge core_clk) disable iff (reset)
    pins.byte_mask[0] |-> ##2 !data_oe[0])
    else $error("masked read lane not floated two clocks later");

  read_drive_a: assert property (@(posedge core_clk) disable iff (reset)
    (!pins.byte_mask[1] ##2 st_reg.rd_valid[cl_idx]) |-> data_oe[1])
    else $error("unmasked read lane not driven");

  refresh_count_a: assert property (@(posedge core_clk) disable iff (reset)
    is_ref |=> (st_reg.refresh_row == $past(st_reg.refresh_row) + 12'h001))
    else $error("auto refresh did not advance the row counter");

  term_stop_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_term && st_reg.burst_active) |=> !st_reg.burst_active)
    else $error("burst terminate did not stop the burst");

  ap_close_a: assert property (@(posedge core_clk) disable iff (reset)
    (burst_done && st_reg.burst_ap && cmd_none)
    |=> !st_reg.open[$past(st_reg.burst_bank)])
    else $error("auto precharge did not close the row");

  ap_keep_a: assert property (@(posedge core_clk) disable iff (reset)
    (burst_done && !st_reg.burst_ap && cmd_none)
    |=> st_reg.open[$past(st_reg.burst_bank)])
    else $error("row closed without auto precharge");

  self_entry_a: assert property (@(posedge core_clk) disable iff (reset)
    self_entry |=> self_refresh_active [*1] ##0 !is_ref)
    else $error("self refresh not entered");

  read_lat_a: assert property (@(posedge core_clk) disable iff (reset)
    (is_rd && new_rw && (st_reg.mode[5:4] == 2'h2))
    |-> ##2 (st_reg.rd_valid[1] && (data_out == $past(rd_word, 2))))
    else $error("read data not presented at latency two");

  closed_access_a: assert property (@(posedge core_clk) disable iff (reset)
    ((is_rd || is_wr) && !st_reg.open[pins.bank_select] && !st_reg.burst_active)
    |=> !st_reg.rd_valid[0])
    else $error("access to a closed bank was carried out");

  self_exit_a: assert property (@(posedge core_clk) disable iff (reset)
    (self_refresh_active && pins.clock_gate_enable) |=> !self_refresh_active)
    else $error("self refresh not left with clock enable high");

  refresh_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !(is_ref || self_entry) |=> $stable(st_reg.refresh_row))
    else $error("refresh counter moved without a refresh");

  mode_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !is_mode |=> $stable(st_reg.mode))
    else $error("mode word changed without mode load");

endmodule

`default_nettype wire

// *** sdram_ctrl_model.sv ***
// memory controller model: drives command pins and write data of the sdram
// assumes core_clk is shared with the device; all waits are whole cycles
`timescale 1ns/10ps
`default_nettype none

module sdram_ctrl_model #(
  parameter int MODE_WAIT = 2,
  parameter int PRE_WAIT  = 1,
  parameter int RFC_WAIT  = 1,
  parameter int REF_GAP   = 156
) (
  input  wire logic                          core_clk,
  output sdram_pkg::cmd_pins_t               pins,
  output logic [sdram_pkg::DATA_W-1:0]       data_in
);
  initial
  begin
    pins    = '1;
    data_in = '0;
  end

  // one command per edge; unused data lines toggle so stale data never passes
  task automatic drive(input logic cs_n, input logic cke, input logic [2:0] code,
    input logic [1:0] b, input logic [11:0] a, input logic [3:0] m,
    input logic [31:0] d, input logic dv);
    @(posedge core_clk);
    pins    <= {cke, cs_n, code, b, a, m};
    data_in <= dv ? d : ~data_in;
  endtask

  // idle cycles are nops with clock enable high
  task automatic idle(input int n);
    repeat (n) drive(1'b0, 1'b1, sdram_pkg::CODE_NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
  endtask

  task automatic after_mode();
    idle(MODE_WAIT);
  endtask

  task automatic after_pre();
    idle(PRE_WAIT);
  endtask

  task automatic after_ref();
    idle(RFC_WAIT);
  endtask

  // distributed refresh: one refresh per interval, nops in between
  task automatic refresh_spaced();
    drive(1'b0, 1'b1, sdram_pkg::CODE_REF, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
    idle(REF_GAP - 1);
  endtask
endmodule

`default_nettype wire

// *** tb.sv ***
// self-checking testbench of the sdram command interface
// assumes the controller model drives the pins; the bench judges the outputs
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
  n_checks++; \
  if ((got) !== (exp)) \
  begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
  end

module tb;
  logic                           core_clk;
  logic                           reset;
  sdram_pkg::cmd_pins_t           pins;
  logic [sdram_pkg::DATA_W-1:0]   data_in;
  logic [sdram_pkg::DATA_W-1:0]   data_out;
  logic [sdram_pkg::LANES-1:0]    data_oe;
  logic                           self_refresh_active;
  logic [sdram_pkg::ROW_W-1:0]    refresh_row;
  int                             num_errors;
  int                             n_checks;
  logic [3:0][31:0]               exp_fc;
  localparam logic [3:0][31:0] W_DATA = {32'hd4c3b2a1, 32'h8f7e6d5c, 32'h01234567, 32'h89abcdef};
  localparam logic [3:0][31:0] V_DATA = {32'h0f0f0f0f, 32'h33cc33cc, 32'h5a5a1234, 32'hfedc0001};
  localparam logic [3:0][3:0]  RMASK  = {4'h0, 4'h8, 4'h0, 4'h2};

  sdram_command_interface dut (
    .core_clk            (core_clk),
    .reset               (reset),
    .pins                (pins),
    .data_in             (data_in),
    .data_out            (data_out),
    .data_oe             (data_oe),
    .self_refresh_active (self_refresh_active),
    .refresh_row         (refresh_row)
  );

  sdram_ctrl_model ctl (
    .core_clk (core_clk),
    .pins     (pins),
    .data_in  (data_in)
  );

  task automatic go(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
    input logic [3:0] m);
    ctl.drive(1'b0, 1'b1, c, b, a, m, 32'h0, 1'b0);
  endtask

  task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic [3:0][31:0] d);
    ctl.drive(1'b0, 1'b1, sdram_pkg::CODE_WRITE, b, {4'h0, c}, 4'h0, d[0], 1'b1);
    for (int k = 1; k < 4; k++)
      ctl.drive(1'b0, 1'b1, sdram_pkg::CODE_NOP, 2'h0, 12'h0, 4'h0, d[k], 1'b1);
  endtask

  // burst of four reads at latency two; lanes follow the mask of two edges before
  task automatic rd(input logic [1:0] b, input logic [7:0] c, input logic ap,
    input logic live, input logic [3:0][31:0] e);
    logic [3:0]  oe;
    logic [31:0] lm;
    go(sdram_pkg::CODE_READ, b, {1'b0, ap, 2'h0, c}, RMASK[0]);
    go(sdram_pkg::CODE_NOP, 2'h0, 12'h0, RMASK[1]);
    for (int k = 0; k < 4; k++)
    begin
      go(sdram_pkg::CODE_NOP, 2'h0, 12'h0, (k < 2) ? RMASK[k+2] : 4'h0);
      @(negedge core_clk);
      oe = live ? ~RMASK[k] : 4'h0;
      lm = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
      `CHK(data_oe, oe)
      `CHK(data_out & lm, e[k] & lm)
    end
  endtask

  task automatic t_reset();
    `CHK(data_oe, 4'h0)
    `CHK(self_refresh_active, 1'b0)
    `CHK(refresh_row, 12'h000)
  endtask

  task automatic t_write_term();
    go(sdram_pkg::CODE_MODE, 2'h3, {6'h0, 2'h2, 1'b0, sdram_pkg::BL_CODE_4}, 4'h0);
    ctl.after_mode();
    go(sdram_pkg::CODE_ACT, 2'h3, 12'hfff, 4'h0);
    wr(2'h3, 8'hfc, W_DATA);
    ctl.drive(1'b0, 1'b1, sdram_pkg::CODE_WRITE, 2'h3, 12'h0fc, 4'h1, 32'ha5a5a5a5, 1'b1);
    go(sdram_pkg::CODE_TERM, 2'h0, 12'h000, 4'h0);
    exp_fc = W_DATA;
    exp_fc[0] = (32'ha5a5a5a5 & 32'hffffff00) | (W_DATA[0] & 32'h000000ff);
    rd(2'h3, 8'hfc, 1'b0, 1'b1, exp_fc);
  endtask

  task automatic t_precharge();
    go(sdram_pkg::CODE_ACT, 2'h0, 12'h001, 4'h0);
    wr(2'h0, 8'h00, V_DATA);
    rd(2'h0, 8'h00, 1'b0, 1'b1, V_DATA);
    go(sdram_pkg::CODE_PRE, 2'h0, 12'h000, 4'h0);
    ctl.after_pre();
    rd(2'h3, 8'hfc, 1'b0, 1'b1, exp_fc);
    rd(2'h0, 8'h00, 1'b0, 1'b0, V_DATA);
    go(sdram_pkg::CODE_ACT, 2'h0, 12'h001, 4'h0);
    go(sdram_pkg::CODE_PRE, 2'h1, 12'h400, 4'h0);
    ctl.after_pre();
    rd(2'h3, 8'hfc, 1'b0, 1'b0, exp_fc);
    rd(2'h0, 8'h00, 1'b0, 1'b0, V_DATA);
  endtask

  task automatic t_autopre();
    go(sdram_pkg::CODE_ACT, 2'h3, 12'hfff, 4'h0);
    rd(2'h3, 8'hfc, 1'b1, 1'b1, exp_fc);
    rd(2'h3, 8'hfc, 1'b0, 1'b0, exp_fc);
    ctl.after_pre();
    go(sdram_pkg::CODE_ACT, 2'h3, 12'hfff, 4'h0);
    rd(2'h3, 8'hfc, 1'b0, 1'b1, exp_fc);
    rd(2'h3, 8'hfc, 1'b0, 1'b1, exp_fc);
  endtask

  task automatic t_deselect();
    ctl.drive(1'b1, 1'b1, sdram_pkg::CODE_WRITE, 2'h3, 12'h0fc, 4'h0, 32'h0, 1'b1);
    ctl.idle(3);
    rd(2'h3, 8'hfc, 1'b0, 1'b1, exp_fc);
    ctl.drive(1'b1, 1'b0, sdram_pkg::CODE_REF, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
    ctl.idle(1);
    @(negedge core_clk);
    `CHK(self_refresh_active, 1'b0)
    `CHK(refresh_row, 12'h000)
  endtask

  task automatic t_refresh();
    go(sdram_pkg::CODE_PRE, 2'h0, 12'h400, 4'h0);
    ctl.after_pre();
    go(sdram_pkg::CODE_REF, 2'h2, 12'h5a5, 4'hf);
    ctl.after_ref();
    @(negedge core_clk);
    `CHK(refresh_row, 12'h001)
    `CHK(self_refresh_active, 1'b0)
    ctl.drive(1'b0, 1'b0, sdram_pkg::CODE_REF, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
    ctl.drive(1'b1, 1'b0, sdram_pkg::CODE_NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
    ctl.drive(1'b1, 1'b0, sdram_pkg::CODE_NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
    @(negedge core_clk);
    `CHK(self_refresh_active, 1'b1)
    `CHK(refresh_row, 12'h002)
    ctl.idle(3);
    @(negedge core_clk);
    `CHK(self_refresh_active, 1'b0)
  endtask

  // continuous page burst cut by terminate, then back to bursts of four
  task automatic t_full_page();
    go(sdram_pkg::CODE_MODE, 2'h0, {6'h0, 2'h2, 1'b0, sdram_pkg::BL_CODE_PAGE}, 4'h0);
    ctl.after_mode();
    go(sdram_pkg::CODE_ACT, 2'h1, 12'h0a5, 4'h0);
    wr(2'h1, 8'h10, V_DATA);
    go(sdram_pkg::CODE_TERM, 2'h0, 12'h000, 4'h0);
    go(sdram_pkg::CODE_PRE, 2'h0, 12'h400, 4'h0);
    ctl.after_pre();
    go(sdram_pkg::CODE_MODE, 2'h0, {6'h0, 2'h2, 1'b0, sdram_pkg::BL_CODE_4}, 4'h0);
    ctl.after_mode();
    go(sdram_pkg::CODE_ACT, 2'h1, 12'h0a5, 4'h0);
    rd(2'h1, 8'h10, 1'b0, 1'b1, V_DATA);
  endtask

  // all rows back to back, then a few at the distributed pace
  task automatic t_refresh_burst();
    go(sdram_pkg::CODE_PRE, 2'h0, 12'h400, 4'h0);
    ctl.after_pre();
    repeat (4095)
    begin
      go(sdram_pkg::CODE_REF, 2'h0, 12'h000, 4'h0);
      ctl.after_ref();
    end
    @(negedge core_clk);
    `CHK(refresh_row, 12'h001)
    go(sdram_pkg::CODE_REF, 2'h0, 12'h000, 4'h0);
    ctl.after_ref();
    @(negedge core_clk);
    `CHK(refresh_row, 12'h002)
    repeat (3) ctl.refresh_spaced();
    @(negedge core_clk);
    `CHK(refresh_row, 12'h005)
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (12000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    reset = 1'b1;
    num_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    t_reset();
    t_write_term();
    t_precharge();
    t_autopre();
    t_deselect();
    t_refresh();
    t_full_page();
    t_refresh_burst();
    give_verdict();
  end
endmodule

`default_nettype wire
